/* File: hw/cfm_clock_failure_monitor.sv */
// clock failure monitor: two oscillator watchdogs, recovery switch, registers
`timescale 1ns/100ps

// How it works
// - detectors left enabled across a source change may flag a spurious failure
// - detectors may be re-enabled any time after the source select write completes
// - precision oscillator enabled after reset; source changes never disable it (here any control write with bit 2 clear turns it off)
// - primary oscillator failure raises a maskable interrupt event
// - primary failure forces the watchdog oscillator onto the system clock
// - forced switch only while watchdog oscillator enabled; reset function not needed
// - primary detector fires when frequency drops below about one kilohertz
// - watchdog oscillator failure raises a nonmaskable interrupt event
// - watchdog oscillator failure never changes the system clock source
// - after a watchdog oscillator failure primary detection stops working
// - watchdog detector declares failure after 8004 clocks without a watchdog edge
module cfm_clock_failure_monitor #(
	parameter int PRIM_FAIL_CYC = cfm_pkg::PRIM_FAIL_CYC,
	parameter int WDOG_FAIL_CYC = cfm_pkg::WDOG_FAIL_CYC,
	parameter int CNT_W = cfm_pkg::CNT_W
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic sys_osc_i,
	input wire logic wdog_osc_i,
	input wire logic [cfm_pkg::ADDR_W-1:0] addr_i,
	input wire logic [cfm_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [cfm_pkg::DATA_W-1:0] rdata_o,
	output logic irq_o,
	output logic nmi_o,
	output logic [cfm_pkg::SEL_W-1:0] clock_source_select_o,
	output logic internal_precision_osc_o,
	output logic wdog_osc_en_o,
	output logic recovery_o
);

	// parking value: the pulse comes on the last cycle of the full silent count
	localparam logic [CNT_W-1:0] PRIM_MAX = CNT_W'(PRIM_FAIL_CYC);
	localparam logic [CNT_W-1:0] WDOG_MAX = CNT_W'(WDOG_FAIL_CYC);

	logic [7:0] oscillator_control_reg;
	logic [7:0] stat;
	logic [7:0] mask;
	logic [7:0] next_ctrl;
	logic [7:0] next_stat;
	logic [7:0] next_mask;
	logic [7:0] next_rdata;
	logic [CNT_W-1:0] prim_cnt;
	logic [CNT_W-1:0] wdog_cnt;
	logic [CNT_W-1:0] next_prim_cnt;
	logic [CNT_W-1:0] next_wdog_cnt;
	logic sys_osc_q;
	logic wdog_osc_q;
	logic wdog_dead;
	logic next_wdog_dead;
	logic [cfm_pkg::SEL_W-1:0] next_sel;
	cfm_pkg::cfm_state_e state;
	cfm_pkg::cfm_state_e next_state;

	logic sys_osc_fail_detect_en;
	logic wdog_osc_fail_detect_en;
	logic prim_edge;
	logic wdog_edge;
	logic prim_pulse;
	logic wdog_pulse;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;
	logic sof_rise;
	logic wof_rise;

	function automatic logic hit(input logic [cfm_pkg::ADDR_W-1:0] a,
		input logic [cfm_pkg::ADDR_W-1:0] b);
		hit = (a == b);
	endfunction : hit

	assign wr_ctrl = wr_i & hit(addr_i, cfm_pkg::ADDR_CTRL);
	assign wr_stat = wr_i & hit(addr_i, cfm_pkg::ADDR_STAT);
	assign wr_mask = wr_i & hit(addr_i, cfm_pkg::ADDR_MASK);

	// inputs are synchronous, so a one-flop history is enough for edges
	assign prim_edge = sys_osc_i ^ sys_osc_q;
	assign wdog_edge = wdog_osc_i ^ wdog_osc_q;

	// primary detection is dead for good once the watchdog clock is lost
	assign sys_osc_fail_detect_en = oscillator_control_reg[cfm_pkg::CTRL_SOF_BIT]
		& ~wdog_dead;
	assign wdog_osc_fail_detect_en = oscillator_control_reg[cfm_pkg::CTRL_WOF_BIT];

	assign sof_rise = wr_ctrl & wdata_i[cfm_pkg::CTRL_SOF_BIT]
		& ~oscillator_control_reg[cfm_pkg::CTRL_SOF_BIT];
	assign wof_rise = wr_ctrl & wdata_i[cfm_pkg::CTRL_WOF_BIT]
		& ~oscillator_control_reg[cfm_pkg::CTRL_WOF_BIT];

	// one pulse per silent gap; the counter parks at its limit afterwards
	assign prim_pulse = ce_i & sys_osc_fail_detect_en & ~prim_edge
		& (prim_cnt == PRIM_MAX - CNT_W'(1));
	assign wdog_pulse = ce_i & wdog_osc_fail_detect_en & ~wdog_edge
		& (wdog_cnt == WDOG_MAX - CNT_W'(1));

	// detectors: counters run on, unaware of source switches
	always_comb begin
		next_prim_cnt = prim_cnt;
		next_wdog_cnt = wdog_cnt;
		next_wdog_dead = wdog_dead | wdog_pulse;
		if (!sys_osc_fail_detect_en || prim_edge || sof_rise) begin
			next_prim_cnt = '0;
		end else if (prim_cnt != PRIM_MAX) begin
			next_prim_cnt = prim_cnt + CNT_W'(1);
		end
		if (!wdog_osc_fail_detect_en || wdog_edge || wof_rise) begin
			next_wdog_cnt = '0;
		end else if (wdog_cnt != WDOG_MAX) begin
			next_wdog_cnt = wdog_cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prim_cnt <= '0;
			wdog_cnt <= '0;
			wdog_dead <= 1'b0;
			sys_osc_q <= 1'b0;
			wdog_osc_q <= 1'b0;
		end else if (ce_i) begin
			prim_cnt <= next_prim_cnt;
			wdog_cnt <= next_wdog_cnt;
			wdog_dead <= next_wdog_dead;
			sys_osc_q <= sys_osc_i;
			wdog_osc_q <= wdog_osc_i;
		end
	end

	// recovery: any control write hands the source back to software
	always_comb begin
		next_state = state;
		case (state)
			cfm_pkg::CFM_NORMAL: begin
				if (prim_pulse && oscillator_control_reg[cfm_pkg::CTRL_WOSC_BIT]) begin
					next_state = cfm_pkg::CFM_RECOVER;
				end
			end
			cfm_pkg::CFM_RECOVER: begin
				if (wr_ctrl) begin
					next_state = cfm_pkg::CFM_NORMAL;
				end
			end
			default: begin
				next_state = cfm_pkg::CFM_NORMAL;
			end
		endcase
	end

	// the watchdog failure pulse plays no part in the select
	always_comb begin
		if (next_state == cfm_pkg::CFM_RECOVER) begin
			next_sel = cfm_pkg::SEL_WDOG;
		end else begin
			next_sel = next_ctrl[cfm_pkg::CTRL_SEL_LSB +: cfm_pkg::SEL_W];
		end
	end

	// registers: status sets beat a same-cycle write-one clear
	always_comb begin
		next_ctrl = oscillator_control_reg;
		next_mask = mask;
		next_stat = stat;
		next_rdata = 8'h00;
		if (wr_ctrl) begin
			next_ctrl = wdata_i;
		end
		if (wr_mask) begin
			next_mask = wdata_i & cfm_pkg::STAT_USED;
		end
		if (wr_stat) begin
			next_stat = stat & ~wdata_i;
		end
		next_stat[cfm_pkg::EV_PRIM] = next_stat[cfm_pkg::EV_PRIM] | prim_pulse;
		next_stat[cfm_pkg::EV_WDOG] = next_stat[cfm_pkg::EV_WDOG] | wdog_pulse;
		if (rd_i) begin
			case (addr_i)
				cfm_pkg::ADDR_CTRL: next_rdata = oscillator_control_reg;
				cfm_pkg::ADDR_STAT: next_rdata = stat;
				cfm_pkg::ADDR_MASK: next_rdata = mask;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			oscillator_control_reg <= cfm_pkg::CTRL_RST;
			stat <= cfm_pkg::STAT_RST;
			mask <= cfm_pkg::MASK_RST;
			rdata_o <= 8'h00;
			state <= cfm_pkg::CFM_NORMAL;
			clock_source_select_o <= cfm_pkg::SEL_IPO;
		end else if (ce_i) begin
			oscillator_control_reg <= next_ctrl;
			stat <= next_stat;
			mask <= next_mask;
			rdata_o <= next_rdata;
			state <= next_state;
			clock_source_select_o <= next_sel;
		end
	end

	assign irq_o = |(stat & mask);
	// not maskable: the handler must learn of a lost watchdog clock
	assign nmi_o = stat[cfm_pkg::EV_WDOG];
	assign internal_precision_osc_o = oscillator_control_reg[cfm_pkg::CTRL_IPO_BIT];
	assign wdog_osc_en_o = oscillator_control_reg[cfm_pkg::CTRL_WOSC_BIT];
	assign recovery_o = (state == cfm_pkg::CFM_RECOVER);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i || !ce_i);

	property p_prim_status;
		prim_pulse |=> stat[cfm_pkg::EV_PRIM] && (!mask[cfm_pkg::EV_PRIM] || irq_o);
	endproperty
	a_prim_status: assert property (p_prim_status) else $error("primary event lost");

	property p_recover_sel;
		prim_pulse && wdog_osc_en_o && !wr_ctrl
			|=> recovery_o && (clock_source_select_o == cfm_pkg::SEL_WDOG);
	endproperty
	a_recover_sel: assert property (p_recover_sel) else $error("no switch to watchdog");

	property p_no_recover_off;
		prim_pulse && !wdog_osc_en_o && !recovery_o |=> !recovery_o;
	endproperty
	a_no_recover_off: assert property (p_no_recover_off) else $error("switch while off");

	property p_prim_count;
		prim_pulse |-> prim_cnt == PRIM_MAX - CNT_W'(1) && $stable(sys_osc_i);
	endproperty
	a_prim_count: assert property (p_prim_count) else $error("primary gap wrong");

	property p_wdog_nmi;
		wdog_pulse |=> nmi_o && stat[cfm_pkg::EV_WDOG];
	endproperty
	a_wdog_nmi: assert property (p_wdog_nmi) else $error("watchdog nmi missing");

	property p_wdog_keep_sel;
		wdog_pulse && !wr_ctrl && !prim_pulse |=> $stable(clock_source_select_o);
	endproperty
	a_wdog_keep_sel: assert property (p_wdog_keep_sel) else $error("source moved");

	property p_prim_dead;
		wdog_dead && !stat[cfm_pkg::EV_PRIM] |=> !stat[cfm_pkg::EV_PRIM];
	endproperty
	a_prim_dead: assert property (p_prim_dead) else $error("primary after dead");

	property p_wdog_count;
		wdog_pulse |-> wdog_cnt == WDOG_MAX - CNT_W'(1) && $stable(wdog_osc_i);
	endproperty
	a_wdog_count: assert property (p_wdog_count) else $error("watchdog gap wrong");

	property p_ipo_kept;
		!wr_ctrl |=> $stable(internal_precision_osc_o);
	endproperty
	a_ipo_kept: assert property (p_ipo_kept) else $error("precision osc changed");

	property p_reenable;
		sof_rise && !wdog_dead |=> prim_cnt == '0;
	endproperty
	a_reenable: assert property (p_reenable) else $error("restart missed");

	property p_recover_hold;
		recovery_o && !wr_ctrl |=> recovery_o && (clock_source_select_o == cfm_pkg::SEL_WDOG);
	endproperty
	a_recover_hold: assert property (p_recover_hold) else $error("recovery dropped");

	property p_recover_exit;
		recovery_o && wr_ctrl |=> !recovery_o;
	endproperty
	a_recover_exit: assert property (p_recover_exit) else $error("recovery stuck");

	property p_wdog_no_recover;
		!recovery_o && !prim_pulse |=> !recovery_o;
	endproperty
	a_wdog_no_recover: assert property (p_wdog_no_recover) else $error("stray switch");

	property p_stat_sticky;
		stat[cfm_pkg::EV_PRIM] && !(wr_stat && wdata_i[cfm_pkg::EV_PRIM]) |=> stat[cfm_pkg::EV_PRIM];
	endproperty
	a_stat_sticky: assert property (p_stat_sticky) else $error("status bit lost");

	property p_rdata_idle;
		!rd_i |=> rdata_o == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

	c_recover: cover property (prim_pulse && wdog_osc_en_o);
	c_wdog_fail: cover property (wdog_pulse);
	c_clear_race: cover property (wr_stat && wdata_i[cfm_pkg::EV_PRIM] && prim_pulse);

endmodule : cfm_clock_failure_monitor

/* File: hw/cfm_pkg.sv */
// constants, register map and state type of the clock failure monitor
package cfm_pkg;

	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_PERIOD_NS = 10;

	// primary failure threshold in hertz, nominal; tolerance is wide
	localparam int PRIM_FAIL_HZ = 1000;
	// longest silent gap, rounded down to whole cycles
	localparam int PRIM_FAIL_CYC = CLK_HZ / PRIM_FAIL_HZ;
	localparam int WDOG_FAIL_CYC = 8004;
	localparam int CNT_W = 17;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 2;

	localparam logic [1:0] ADDR_CTRL = 2'h0;
	localparam logic [1:0] ADDR_STAT = 2'h1;
	localparam logic [1:0] ADDR_MASK = 2'h2;

	localparam int CTRL_SOF_BIT = 0;
	localparam int CTRL_WOF_BIT = 1;
	localparam int CTRL_IPO_BIT = 2;
	localparam int CTRL_WOSC_BIT = 3;
	localparam int CTRL_SEL_LSB = 4;
	localparam int SEL_W = 3;

	localparam int EV_PRIM = 0;
	localparam int EV_WDOG = 1;

	localparam logic [7:0] CTRL_RST = 8'h0c;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] STAT_USED = 8'h03;

	localparam logic [2:0] SEL_IPO = 3'h0;
	localparam logic [2:0] SEL_WDOG = 3'h3;

	typedef enum logic [0:0] {
		CFM_NORMAL = 1'b0,
		CFM_RECOVER = 1'b1
	} cfm_state_e;

endpackage : cfm_pkg

/* File: verification/cfm_osc_model.sv */
// oscillator model for the clock failure monitor bench
`timescale 1ns/100ps
module cfm_osc_model (
	input wire logic clk_i,
	input wire logic sys_run_i,
	input wire logic wdog_run_i,
	output logic sys_osc_o,
	output logic wdog_osc_o
);
	logic [1:0] div;
	initial begin
		sys_osc_o = 1'b0;
		wdog_osc_o = 1'b0;
		div = 2'h0;
	end
	// a stopped oscillator sticks at its last level, like a dead crystal
	always @(posedge clk_i) begin
		div <= div + 2'h1;
		if (sys_run_i) sys_osc_o <= ~sys_osc_o;
		// watchdog runs slower, well inside the failure gap
		if (wdog_run_i && div == 2'h3) wdog_osc_o <= ~wdog_osc_o;
	end
endmodule : cfm_osc_model

/* File: verification/test_cfm_clock_failure_monitor.sv */
// self-checking bench for the clock failure monitor
`timescale 1ns/100ps
module test_cfm_clock_failure_monitor;
	logic clk_i, rst_n_i, wr_i, rd_i, sys_run, wdog_run, sys_osc, wdog_osc;
	logic [1:0] addr_i;
	logic [7:0] wdata_i, rdata_o;
	logic irq_o, nmi_o, ipo_o, wen_o, rec_o;
	logic [2:0] sel_o;
	int miscompares = 0;
	int total_checks = 0;
	cfm_clock_failure_monitor #(.PRIM_FAIL_CYC(40), .WDOG_FAIL_CYC(30)) i_dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .sys_osc_i(sys_osc),
		.wdog_osc_i(wdog_osc), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .nmi_o(nmi_o),
		.clock_source_select_o(sel_o), .internal_precision_osc_o(ipo_o),
		.wdog_osc_en_o(wen_o), .recovery_o(rec_o));
	// the watchdog oscillator only runs while software keeps it enabled
	cfm_osc_model i_osc (.clk_i(clk_i), .sys_run_i(sys_run),
		.wdog_run_i(wdog_run & wen_o), .sys_osc_o(sys_osc), .wdog_osc_o(wdog_osc));
	always #5 clk_i = ~clk_i;
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk("rdata", exp, rdata_o);
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	initial begin
		#20000;
		miscompares++;
		close_out();
	end
	initial begin
		clk_i = 1'b0; rst_n_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 2'h0;
		wdata_i = 8'h00; sys_run = 1'b1; wdog_run = 1'b1;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(cfm_pkg::ADDR_CTRL, 8'h0c);
		rd(cfm_pkg::ADDR_STAT, 8'h00);
		rd(cfm_pkg::ADDR_MASK, 8'h00);
		rd(2'h3, 8'h00);
		chk("ipo", 8'h01, {7'h0, ipo_o});
		$display("reset test done");
		wr(cfm_pkg::ADDR_CTRL, 8'h1c);
		chk("sel", 8'h01, {5'h0, sel_o});
		chk("ipo", 8'h01, {7'h0, ipo_o});
		wr(cfm_pkg::ADDR_CTRL, 8'h1d);
		cyc(60);
		rd(cfm_pkg::ADDR_STAT, 8'h00);
		$display("source change test done");
		wr(cfm_pkg::ADDR_CTRL, 8'h0c);
		wr(cfm_pkg::ADDR_CTRL, 8'h0d);
		wr(cfm_pkg::ADDR_MASK, 8'h01);
		sys_run <= 1'b0;
		cyc(40);
		chk("irq", 8'h00, {7'h0, irq_o});
		cyc(20);
		chk("irq", 8'h01, {7'h0, irq_o});
		chk("rec", 8'h01, {7'h0, rec_o});
		chk("sel", 8'h03, {5'h0, sel_o});
		chk("nmi", 8'h00, {7'h0, nmi_o});
		rd(cfm_pkg::ADDR_STAT, 8'h01);
		wr(cfm_pkg::ADDR_STAT, 8'h01);
		chk("irq", 8'h00, {7'h0, irq_o});
		wr(cfm_pkg::ADDR_CTRL, 8'h0c);
		chk("rec", 8'h00, {7'h0, rec_o});
		sys_run <= 1'b1;
		$display("recovery test done");
		wr(cfm_pkg::ADDR_MASK, 8'h00);
		wr(cfm_pkg::ADDR_CTRL, 8'h05);
		sys_run <= 1'b0;
		cyc(60);
		chk("rec", 8'h00, {7'h0, rec_o});
		chk("sel", 8'h00, {5'h0, sel_o});
		chk("irq", 8'h00, {7'h0, irq_o});
		rd(cfm_pkg::ADDR_STAT, 8'h01);
		sys_run <= 1'b1;
		wr(cfm_pkg::ADDR_STAT, 8'h01);
		wr(cfm_pkg::ADDR_CTRL, 8'h0c);
		$display("no recovery test done");
		wr(cfm_pkg::ADDR_CTRL, 8'h0e);
		wdog_run <= 1'b0;
		sys_run <= 1'b0;
		cyc(20);
		chk("nmi", 8'h00, {7'h0, nmi_o});
		cyc(20);
		chk("nmi", 8'h01, {7'h0, nmi_o});
		chk("irq", 8'h00, {7'h0, irq_o});
		chk("sel", 8'h00, {5'h0, sel_o});
		chk("rec", 8'h00, {7'h0, rec_o});
		rd(cfm_pkg::ADDR_STAT, 8'h02);
		wr(cfm_pkg::ADDR_CTRL, 8'h0d);
		sys_run <= 1'b0;
		cyc(60);
		rd(cfm_pkg::ADDR_STAT, 8'h02);
		chk("rec", 8'h00, {7'h0, rec_o});
		$display("watchdog failure test done");
		close_out();
	end
endmodule : test_cfm_clock_failure_monitor
